//--- dacx_pkg.sv
// Purpose: constants for the converter control and timing-error registers
// Assumes: 8-bit register port, byte-wide registers at their own offsets
// Notes:   reset values and field positions shared by design and tests
package dacx_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] DACX_AUX_ONE_LO  = 8'h0d;
    localparam logic [7:0] DACX_AUX_ONE_CTL = 8'h0e;
    localparam logic [7:0] DACX_GAIN_LO     = 8'h0f;
    localparam logic [7:0] DACX_GAIN_HI     = 8'h10;
    localparam logic [7:0] DACX_AUX_TWO_LO  = 8'h11;
    localparam logic [7:0] DACX_AUX_TWO_CTL = 8'h12;
    localparam logic [7:0] DACX_RSV_FIRST   = 8'h13;
    localparam logic [7:0] DACX_RSV_LAST    = 8'h18;
    localparam logic [7:0] DACX_IRQ         = 8'h19;
    localparam logic [7:0] DACX_IRQ_CLR     = 8'h1a;
    localparam logic [7:0] DACX_REVISION    = 8'h1f;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int DACX_HI_MSB     = 1;
    localparam int DACX_NEG_BIT    = 7;
    localparam int DACX_SINK_BIT   = 6;
    localparam int DACX_PD_BIT     = 5;
    localparam int DACX_SLEEP_BIT  = 7;
    localparam int DACX_QPD_BIT    = 6;
    localparam int DACX_DERR_BIT   = 7;
    localparam int DACX_SERR_BIT   = 6;
    localparam int DACX_TYPE_BIT   = 4;
    localparam int DACX_DEN_BIT    = 3;
    localparam int DACX_SEN_BIT    = 2;
    localparam int DACX_LOOP_BIT   = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] DACX_ZERO_RST    = 8'h00;
    localparam logic [1:0] DACX_GAIN_HI_RST = 2'h1;
    localparam logic [7:0] DACX_GAIN_LO_RST = 8'h7c;
    // arbitrary value, not a real part's revision
    localparam logic [7:0] DACX_REV_DEFAULT = 8'h01;

endpackage

//--- dacx_regs.sv
// Purpose: second-channel gain, two auxiliary converters, timing-error irq
// Assumes: error detectors and sync input come from another clock domain
// Notes:   one-cycle read latency, no wait states, clock enable freezes all
//
// How it works
// - second gain is ten bits: high register bits 1:0, low register byte
// - aux one code ten bits, 0x0e bits 1:0 over 0x0d byte
// - aux one bit 7 picks negative output, bit 6 picks sinking
// - aux one bit 5 powers it down, resets to zero
// - aux two code ten bits, 0x12 bits 1:0 over 0x11, reset zero
// - aux two bit 7 picks negative output, bit 6 picks sinking
// - aux two bit 5 set powers it down, clear keeps it on
// - data-port timing violation sets irq bit 7
// - sync-input timing violation sets irq bit 6
// - both error flags stay set until cleared
// - reading the irq register clears flags; writes cannot set them
// - bit 4 gives violation kind: one setup, zero hold
// - bit 3 enables data error interrupt, reset masked
// - bit 2 enables sync error interrupt, reset masked
// - bit 0 loops outgoing sync back onto the sync input path
// - read-only revision byte at 0x1f
`timescale 1ns/1ns

module dacx_regs
    import dacx_pkg::*;
#(
    parameter logic [7:0] REVISION = DACX_REV_DEFAULT
) (
    // clock, reset, enable
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire logic       i_clk_en,
    // register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // timing detectors and sync, foreign domain
    input  wire logic       i_data_err,
    input  wire logic       i_data_err_setup,
    input  wire logic       i_sync_err,
    input  wire logic       i_sync_in,
    // outgoing sync from local logic
    input  wire logic       i_sync_out,
    // second main channel
    output logic      [9:0] o_second_gain,
    output logic            o_second_sleep,
    output logic            o_second_pd,
    // auxiliary converter one
    output logic      [9:0] o_aux_one_code,
    output logic            o_aux_one_neg_out,
    output logic            o_aux_one_sink,
    output logic            o_aux_one_pd,
    // auxiliary converter two
    output logic      [9:0] o_aux_two_code,
    output logic            o_aux_two_neg_out,
    output logic            o_aux_two_sink,
    output logic            o_aux_two_pd,
    // sync path and interrupt
    output logic            o_sync_path,
    output logic            o_irq
);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            meta_reg <= 4'h0;
            sync_reg <= 4'h0;
        end else if (i_clk_en) begin
            meta_reg <= {i_sync_in, i_data_err_setup, i_sync_err, i_data_err};
            sync_reg <= meta_reg;
        end
    end

    wire logic derr_s  = sync_reg[0];
    wire logic serr_s  = sync_reg[1];
    wire logic setup_s = sync_reg[2];
    wire logic syncr_s = sync_reg[3];

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    assign wr_en = i_clk_en && i_wr;
    assign rd_en = i_clk_en && i_rd;

    // ----------------------------------------------------------------
    // gain and auxiliary registers
    // ----------------------------------------------------------------
    logic [1:0] aux_one_ctl_hi;
    logic [1:0] aux_two_ctl_hi;

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_second_gain  <= {DACX_GAIN_HI_RST, DACX_GAIN_LO_RST};
            o_second_sleep <= 1'b0;
            o_second_pd    <= 1'b0;
        end else if (wr_en && i_addr == DACX_GAIN_LO) begin
            o_second_gain[7:0] <= i_wdata;
        end else if (wr_en && i_addr == DACX_GAIN_HI) begin
            o_second_gain[9:8] <= i_wdata[DACX_HI_MSB:0];
            o_second_sleep     <= i_wdata[DACX_SLEEP_BIT];
            o_second_pd        <= i_wdata[DACX_QPD_BIT];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_aux_one_code    <= 10'h000;
            o_aux_one_neg_out <= 1'b0;
            o_aux_one_sink    <= 1'b0;
            o_aux_one_pd      <= 1'b0;
        end else if (wr_en && i_addr == DACX_AUX_ONE_LO) begin
            o_aux_one_code[7:0] <= i_wdata;
        end else if (wr_en && i_addr == DACX_AUX_ONE_CTL) begin
            o_aux_one_code[9:8] <= i_wdata[DACX_HI_MSB:0];
            o_aux_one_neg_out   <= i_wdata[DACX_NEG_BIT];
            o_aux_one_sink      <= i_wdata[DACX_SINK_BIT];
            o_aux_one_pd        <= i_wdata[DACX_PD_BIT];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_aux_two_code    <= 10'h000;
            o_aux_two_neg_out <= 1'b0;
            o_aux_two_sink    <= 1'b0;
            o_aux_two_pd      <= 1'b0;
        end else if (wr_en && i_addr == DACX_AUX_TWO_LO) begin
            o_aux_two_code[7:0] <= i_wdata;
        end else if (wr_en && i_addr == DACX_AUX_TWO_CTL) begin
            o_aux_two_code[9:8] <= i_wdata[DACX_HI_MSB:0];
            o_aux_two_neg_out   <= i_wdata[DACX_NEG_BIT];
            o_aux_two_sink      <= i_wdata[DACX_SINK_BIT];
            o_aux_two_pd        <= i_wdata[DACX_PD_BIT];
        end
    end

    assign aux_one_ctl_hi = o_aux_one_code[9:8];
    assign aux_two_ctl_hi = o_aux_two_code[9:8];

    // ----------------------------------------------------------------
    // timing-error flags
    // ----------------------------------------------------------------
    logic derr_reg;
    logic serr_reg;
    logic type_reg;
    logic den_reg;
    logic sen_reg;
    logic loop_reg;
    logic irq_rd;
    logic clr_wr;

    assign irq_rd = rd_en && i_addr == DACX_IRQ;
    assign clr_wr = wr_en && i_addr == DACX_IRQ_CLR;

    // a violation present in the clearing cycle keeps its flag set
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            derr_reg <= 1'b0;
            type_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (derr_s) begin
                derr_reg <= 1'b1;
                type_reg <= setup_s;
            end else if (irq_rd
                         || (clr_wr && i_wdata[DACX_DERR_BIT])) begin
                derr_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            serr_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (serr_s) begin
                serr_reg <= 1'b1;
            end else if (irq_rd
                         || (clr_wr && i_wdata[DACX_SERR_BIT])) begin
                serr_reg <= 1'b0;
            end
        end
    end

    // flags are read-only here: only enables and loopback are writable
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            den_reg  <= 1'b0;
            sen_reg  <= 1'b0;
            loop_reg <= 1'b0;
        end else if (wr_en && i_addr == DACX_IRQ) begin
            den_reg  <= i_wdata[DACX_DEN_BIT];
            sen_reg  <= i_wdata[DACX_SEN_BIT];
            loop_reg <= i_wdata[DACX_LOOP_BIT];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_irq <= 1'b0;
        end else if (i_clk_en) begin
            // one cycle behind the flags, so the output is a flop
            o_irq <= (derr_reg && den_reg)
                     || (serr_reg && sen_reg);
        end
    end

    // ----------------------------------------------------------------
    // sync loopback
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_sync_path <= 1'b0;
        end else if (i_clk_en) begin
            o_sync_path <= loop_reg ? i_sync_out : syncr_s;
        end
    end

    // ----------------------------------------------------------------
    // read-back
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = DACX_ZERO_RST;
        unique case (i_addr)
            DACX_AUX_ONE_LO:  rd_mux = o_aux_one_code[7:0];
            DACX_AUX_ONE_CTL: rd_mux = {o_aux_one_neg_out, o_aux_one_sink,
                                        o_aux_one_pd, 3'h0, aux_one_ctl_hi};
            DACX_GAIN_LO:     rd_mux = o_second_gain[7:0];
            DACX_GAIN_HI:     rd_mux = {o_second_sleep, o_second_pd, 4'h0,
                                        o_second_gain[9:8]};
            DACX_AUX_TWO_LO:  rd_mux = o_aux_two_code[7:0];
            DACX_AUX_TWO_CTL: rd_mux = {o_aux_two_neg_out, o_aux_two_sink,
                                        o_aux_two_pd, 3'h0, aux_two_ctl_hi};
            DACX_IRQ:         rd_mux = {derr_reg, serr_reg, 1'b0, type_reg,
                                        den_reg, sen_reg, 1'b0, loop_reg};
            DACX_REVISION:    rd_mux = REVISION;
            // reserved and unmapped addresses read zero
            default:          rd_mux = DACX_ZERO_RST;
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_rdata <= DACX_ZERO_RST;
        end else if (i_clk_en) begin
            o_rdata <= i_rd ? rd_mux : DACX_ZERO_RST;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_gain_word;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (wr_en && i_addr == DACX_GAIN_HI)
            |=> o_second_gain[9:8] == $past(i_wdata[1:0])
                && $stable(o_second_gain[7:0]);
    endproperty
    a_gain_word: assert property (p_gain_word)
        else $error("second gain high bits not loaded");

    property p_aux_one_ctl;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (wr_en && i_addr == DACX_AUX_ONE_CTL)
            |=> {o_aux_one_neg_out, o_aux_one_sink, o_aux_one_pd,
                 o_aux_one_code[9:8]}
                == {$past(i_wdata[7:5]), $past(i_wdata[1:0])};
    endproperty
    a_aux_one_ctl: assert property (p_aux_one_ctl)
        else $error("aux one control fields wrong");

    property p_aux_two_lo;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (wr_en && i_addr == DACX_AUX_TWO_LO)
            |=> o_aux_two_code[7:0] == $past(i_wdata)
                && $stable(o_aux_two_pd);
    endproperty
    a_aux_two_lo: assert property (p_aux_two_lo)
        else $error("aux two low byte not loaded");

    property p_aux_two_pd;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (wr_en && i_addr == DACX_AUX_TWO_CTL)
            |=> o_aux_two_pd == $past(i_wdata[5])
                && o_aux_two_neg_out == $past(i_wdata[7]);
    endproperty
    a_aux_two_pd: assert property (p_aux_two_pd)
        else $error("aux two power-down wrong");

    property p_derr_set;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_clk_en && i_data_err) ##1 i_clk_en ##1 i_clk_en
            |=> derr_reg && type_reg == $past(setup_s);
    endproperty
    a_derr_set: assert property (p_derr_set)
        else $error("data error flag not set");

    property p_serr_sticky;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (serr_reg && !irq_rd && !clr_wr) |=> serr_reg;
    endproperty
    a_serr_sticky: assert property (p_serr_sticky)
        else $error("sync error flag dropped");

    property p_read_clears;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (irq_rd && !derr_s && !serr_s)
            |=> !derr_reg && !serr_reg ##1 o_irq == 1'b0;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("irq read did not clear flags");

    property p_irq_mask;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_clk_en && !den_reg && !sen_reg) |=> !o_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("masked error raised irq");

    property p_loopback;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_clk_en && loop_reg) |=> o_sync_path == $past(i_sync_out);
    endproperty
    a_loopback: assert property (p_loopback)
        else $error("sync loopback path wrong");

    property p_reserved;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (rd_en && i_addr >= DACX_RSV_FIRST && i_addr <= DACX_RSV_LAST)
            |=> o_rdata == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved address read non-zero");

    property p_revision;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (rd_en && i_addr == DACX_REVISION) |=> o_rdata == REVISION;
    endproperty
    a_revision: assert property (p_revision)
        else $error("revision read wrong");

    property p_aux_one_lo;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (wr_en && i_addr == DACX_AUX_ONE_LO)
            |=> o_aux_one_code[7:0] == $past(i_wdata)
                && $stable(o_aux_one_code[9:8]);
    endproperty
    a_aux_one_lo: assert property (p_aux_one_lo)
        else $error("aux one low byte not loaded");

    property p_aux_two_ctl;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (wr_en && i_addr == DACX_AUX_TWO_CTL)
            |=> o_aux_two_sink == $past(i_wdata[6])
                && o_aux_two_code[9:8] == $past(i_wdata[1:0]);
    endproperty
    a_aux_two_ctl: assert property (p_aux_two_ctl)
        else $error("aux two sink or high bits wrong");

endmodule

//--- dacx_regs_tb.sv
// Purpose: self-checking bench for the converter control and irq registers
// Assumes: one clock, synchronous active-low reset, enable low in one test
// Notes:   error inputs are driven as slow levels to pass the synchronisers
`timescale 1ns/1ns

module dacx_regs_tb
    import dacx_pkg::*;
;
    // arbitrary revision value for this build, not a real part's code
    localparam logic [7:0] TB_REV = 8'h5a;

    logic       i_clk_sys;
    logic       i_resetn;
    logic       i_clk_en;
    logic [7:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    logic [7:0] o_rdata;
    logic       i_data_err;
    logic       i_data_err_setup;
    logic       i_sync_err;
    logic       i_sync_in;
    logic       i_sync_out;
    logic [9:0] o_second_gain;
    logic       o_second_sleep;
    logic       o_second_pd;
    logic [9:0] o_aux_one_code;
    logic       o_aux_one_neg_out;
    logic       o_aux_one_sink;
    logic       o_aux_one_pd;
    logic [9:0] o_aux_two_code;
    logic       o_aux_two_neg_out;
    logic       o_aux_two_sink;
    logic       o_aux_two_pd;
    logic       o_sync_path;
    logic       o_irq;
    int         fails;
    int         n_checks;
    logic [7:0] r;

    dacx_regs #(.REVISION(TB_REV)) uut (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_data_err(i_data_err),
        .i_data_err_setup(i_data_err_setup), .i_sync_err(i_sync_err),
        .i_sync_in(i_sync_in), .i_sync_out(i_sync_out),
        .o_second_gain(o_second_gain), .o_second_sleep(o_second_sleep),
        .o_second_pd(o_second_pd), .o_aux_one_code(o_aux_one_code),
        .o_aux_one_neg_out(o_aux_one_neg_out), .o_aux_one_sink(o_aux_one_sink),
        .o_aux_one_pd(o_aux_one_pd), .o_aux_two_code(o_aux_two_code),
        .o_aux_two_neg_out(o_aux_two_neg_out), .o_aux_two_sink(o_aux_two_sink),
        .o_aux_two_pd(o_aux_two_pd), .o_sync_path(o_sync_path), .o_irq(o_irq)
    );

    // ----------------------------------------------------------------
    // clock, bus and compare helpers
    // ----------------------------------------------------------------
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic chk(input string nm, input logic [9:0] exp,
                       input logic [9:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask

    task automatic chkb(input string nm, input logic exp, input logic got);
        chk(nm, {9'h0, exp}, {9'h0, got});
    endtask

    // strobe released on the taking edge, so calls never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    // level held long enough for the two-flop synchroniser
    task automatic pulse(input bit is_sync, input logic setup);
        @(posedge i_clk_sys);
        if (is_sync) begin
            i_sync_err <= 1'b1;
        end else begin
            i_data_err       <= 1'b1;
            i_data_err_setup <= setup;
        end
        repeat (4) @(posedge i_clk_sys);
        i_sync_err <= 1'b0;
        i_data_err <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk("gain rst", 10'h17c, o_second_gain);
        chkb("aux one pd rst", 1'b0, o_aux_one_pd);
        chk("aux two code rst", 10'h0, o_aux_two_code);
        rd(DACX_REVISION, r);
        chk("revision", {2'h0, TB_REV}, {2'h0, r});
        rd(DACX_IRQ, r);
        chk("irq reg rst", 10'h0, {2'h0, r});
        $display("test reset done");
    endtask

    task automatic t_aux();
        logic [7:0] lo [2];
        logic [7:0] ct [2];
        logic [9:0] c1;
        lo = '{8'hff, 8'h00};
        ct = '{8'he3, 8'h02};
        for (int i = 0; i < 2; i++) begin
            wr(DACX_AUX_ONE_LO, lo[i]);
            wr(DACX_AUX_ONE_CTL, ct[i]);
            wr(DACX_AUX_TWO_LO, ~lo[i]);
            wr(DACX_AUX_TWO_CTL, ~ct[i]);
            c1 = {ct[i][1:0], lo[i]};
            chk("aux one code", c1, o_aux_one_code);
            chkb("aux one neg", ct[i][7], o_aux_one_neg_out);
            chkb("aux one sink", ct[i][6], o_aux_one_sink);
            chkb("aux one pd", ct[i][5], o_aux_one_pd);
            chk("aux two code", ~c1, o_aux_two_code);
            chkb("aux two neg", ~ct[i][7], o_aux_two_neg_out);
            chkb("aux two sink", ~ct[i][6], o_aux_two_sink);
            chkb("aux two pd", ~ct[i][5], o_aux_two_pd);
            rd(DACX_AUX_TWO_LO, r);
            chk("aux two lo rd", {2'h0, ~lo[i]}, {2'h0, r});
        end
        $display("test aux done");
    endtask

    // a write with the enable low must leave every register alone
    task automatic t_freeze();
        @(posedge i_clk_sys);
        i_clk_en <= 1'b0;
        wr(DACX_AUX_ONE_LO, 8'h00);
        chk("frozen code", 10'h200, o_aux_one_code);
        @(posedge i_clk_sys);
        i_clk_en <= 1'b1;
        #1;
        $display("test freeze done");
    endtask

    task automatic t_gain();
        wr(DACX_GAIN_LO, 8'ha5);
        wr(DACX_GAIN_HI, 8'h02);
        chk("gain", 10'h2a5, o_second_gain);
        chkb("sleep", 1'b0, o_second_sleep);
        chkb("pd", 1'b0, o_second_pd);
        wr(DACX_GAIN_HI, 8'hc1);
        chk("gain hi", 10'h1a5, o_second_gain);
        chkb("sleep set", 1'b1, o_second_sleep);
        chkb("pd set", 1'b1, o_second_pd);
        rd(DACX_GAIN_HI, r);
        chk("gain hi rd", 10'h0c1, {2'h0, r});
        $display("test gain done");
    endtask

    task automatic t_reserved();
        for (int a = 8'h13; a <= 8'h18; a++) begin
            wr(8'(a), 8'hff);
            rd(8'(a), r);
            chk("reserved rd", 10'h0, {2'h0, r});
        end
        wr(DACX_REVISION, 8'h00);
        rd(DACX_REVISION, r);
        chk("revision ro", {2'h0, TB_REV}, {2'h0, r});
        rd(8'h30, r);
        chk("unmapped rd", 10'h0, {2'h0, r});
        chk("aux two kept", 10'h1ff, o_aux_two_code);
        chk("gain kept", 10'h1a5, o_second_gain);
        $display("test reserved done");
    endtask

    task automatic t_irq_sw();
        // flag bits must ignore writes; enables and loopback take them
        wr(DACX_IRQ, 8'hff);
        rd(DACX_IRQ, r);
        chk("irq write", 10'h00d, {2'h0, r});
        chkb("irq pin idle", 1'b0, o_irq);
        wr(DACX_IRQ, 8'h00);
        $display("test irq write done");
    endtask

    task automatic t_sync_err();
        pulse(1'b1, 1'b0);
        chkb("irq masked", 1'b0, o_irq);
        wr(DACX_IRQ, 8'h04);
        @(posedge i_clk_sys);
        #1;
        chkb("irq sync en", 1'b1, o_irq);
        rd(DACX_IRQ, r);
        chk("sync flag", 10'h044, {2'h0, r});
        repeat (2) @(posedge i_clk_sys);
        #1;
        chkb("irq after rd", 1'b0, o_irq);
        rd(DACX_IRQ, r);
        chk("sync cleared", 10'h004, {2'h0, r});
        $display("test sync error done");
    endtask

    task automatic t_data_err();
        wr(DACX_IRQ, 8'h08);
        pulse(1'b0, 1'b1);
        chkb("irq data en", 1'b1, o_irq);
        rd(DACX_IRQ, r);
        chk("data setup", 10'h098, {2'h0, r});
        pulse(1'b0, 1'b0);
        wr(DACX_IRQ_CLR, 8'h80);
        @(posedge i_clk_sys);
        #1;
        chkb("irq after clr", 1'b0, o_irq);
        rd(DACX_IRQ, r);
        chk("data cleared", 10'h0, {2'h0, r & 8'hc0});
        pulse(1'b0, 1'b0);
        rd(DACX_IRQ, r);
        chk("data hold", 10'h088, {2'h0, r});
        $display("test data error done");
    endtask

    task automatic t_loop();
        wr(DACX_IRQ, 8'h01);
        for (int i = 0; i < 2; i++) begin
            @(posedge i_clk_sys);
            i_sync_out <= ~i_sync_out;
            repeat (2) @(posedge i_clk_sys);
            #1;
            chkb("loop path", i_sync_out, o_sync_path);
        end
        wr(DACX_IRQ, 8'h00);
        @(posedge i_clk_sys);
        i_sync_in <= 1'b1;
        repeat (5) @(posedge i_clk_sys);
        #1;
        chkb("sync in path", 1'b1, o_sync_path);
        $display("test loopback done");
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        fails            = 0;
        n_checks         = 0;
        i_resetn         = 1'b0;
        i_clk_en         = 1'b1;
        i_addr           = 8'h00;
        i_wdata          = 8'h00;
        i_wr             = 1'b0;
        i_rd             = 1'b0;
        i_data_err       = 1'b0;
        i_data_err_setup = 1'b0;
        i_sync_err       = 1'b0;
        i_sync_in        = 1'b0;
        i_sync_out       = 1'b0;
        repeat (16) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        #1;
        t_reset();
        t_aux();
        t_freeze();
        t_gain();
        t_reserved();
        t_irq_sw();
        t_sync_err();
        t_data_err();
        t_loop();
        print_verdict();
    end

    // the full run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        fails++;
        print_verdict();
    end

endmodule
